// file: shared/sdx_pkg.sv
package sdx_pkg;

   // register byte offsets (each register one aligned word)
   localparam logic [7:0] ADDR_XFER = 8'h00;  // transfer_type_reg
   localparam logic [7:0] ADDR_ATTR = 8'h04;  // block_attributes
   localparam logic [7:0] ADDR_DMA  = 8'h08;  // dma_system_address
   localparam logic [7:0] ADDR_STAT = 8'h0c;  // status flags

   // transfer_type_reg fields
   localparam int XT_START     = 0;  // write one: start a data transfer
   localparam int XT_BLOCK_COUNT_ENABLE      = 1;  // block_count_enable
   localparam int XT_AUTOSTOP  = 2;  // auto_stop_enable
   localparam int XT_MULTI     = 3;  // multi-block transfer
   localparam int XT_DMA       = 4;  // internal dma enable
   localparam int XT_DATA_RST  = 5;  // write one: data path reset
   localparam int XT_W         = 6;
   localparam logic [XT_W-1:0] XT_RESET = 6'h00;

   // block_attributes fields
   localparam int SIZE_LSB = 0;   // block_size_field
   localparam int SIZE_W   = 13;
   localparam int CNT_LSB  = 16;  // remaining_block_count
   localparam int CNT_W    = 16;
   localparam logic [SIZE_W-1:0] SIZE_RESET = 13'h0000;
   localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
   localparam logic [31:0]       DMA_RESET  = 32'h0000_0000;

   // status fields; all but busy are sticky, write one to clear
   localparam int ST_BUSY  = 0;  // transfer or stop under way
   localparam int ST_DONE  = 1;  // transfer complete
   localparam int ST_CRC   = 2;  // block crc error
   localparam int ST_DMA   = 3;  // dma system bus error
   localparam int ST_AS_TO = 4;  // auto stop response timeout
   localparam int ST_AS_CE = 5;  // auto stop response crc error
   localparam int ST_AS_NS = 6;  // auto stop conflict or not sent
   localparam int ST_AS_GO = 7;  // auto stop was issued
   localparam int ST_W     = 8;
   localparam logic [ST_W-1:0] ST_RESET = 8'h00;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // controller states
   typedef enum logic [1:0] {
      st_idle,
      st_data,
      st_stop
   } sdx_state_type;

   // answer of the command engine to the automatic stop command
   typedef struct packed {
      logic ok;        // response good
      logic timeout;   // no response
      logic crc_err;   // response crc bad
      logic conflict;  // line conflict, command not sent
   } sdx_stop_resp_type;

   // true for any mapped register offset
   function automatic logic sdx_mapped(input logic [7:0] a);
      return (a == ADDR_XFER) || (a == ADDR_ATTR) || (a == ADDR_DMA) || (a == ADDR_STAT);
   endfunction : sdx_mapped

   // merge write data into an old word under byte strobes
   function automatic logic [31:0] sdx_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (wd & m);
   endfunction : sdx_merge

endpackage : sdx_pkg

// file: core/sdx_link_sampler.sv
`timescale 1ns/1ps
// brings card-side block strobes into aclk and finds card clock rising edges
module sdx_link_sampler (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // card side, foreign domain
   input  wire logic card_clk,
   input  wire logic card_blk_done,
   input  wire logic card_blk_crc_bad,
   // aclk side
   output logic      blk_ev,
   output logic      blk_crc_bad
);
   logic [2:0] sync1;  // first stage, read only by sync2
   logic [2:0] sync2;  // second stage: clk, done, crc
   logic       clk_d;  // delayed synced card clock

   // two flops on every foreign input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         clk_d <= 1'b0;
      end else begin
         sync1 <= {card_clk, card_blk_done, card_blk_crc_bad};
         sync2 <= sync1;
         clk_d <= sync2[2];
      end
   end

   // block strobe counts once, at a card clock rising edge
   assign blk_ev      = sync2[2] & ~clk_d & sync2[1];
   assign blk_crc_bad = sync2[0];
endmodule : sdx_link_sampler

// file: core/sdx_xfer_ctrl.sv
`timescale 1ns/1ps
// Contract
// - crc error mid-transfer: no automatic stop
// - crc error in final block: stop still sent
// - dma bus error aborts dma, flags error
// - dma address holds next burst start
// - block count moves only with count enable
// - auto stop after final multi-block block
// - addressed commands carry no data
module sdx_xfer_ctrl (
   // clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // axi4-lite slave
   input  wire logic [7:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [7:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // card data path, card clock domain
   input  wire logic                       card_clk,
   input  wire logic                       card_blk_done,
   input  wire logic                       card_blk_crc_bad,
   output logic                            data_en,
   // internal dma engine
   output logic                            dma_run,
   input  wire logic                       dma_bus_err,
   input  wire logic                       dma_burst_done,
   output logic [31:0]                     dma_addr,
   // command engine, automatic stop
   output logic                            stop_req,
   input  wire sdx_pkg::sdx_stop_resp_type stop_resp
);
   import sdx_pkg::*;

   sdx_state_type     state;        // controller state
   logic [XT_W-1:0]   xfer_ctl;     // stored transfer_type_reg bits
   logic [SIZE_W-1:0] blk_size;     // block_size_field
   logic [CNT_W-1:0]  blk_cnt;      // remaining_block_count
   logic [ST_W-1:0]   status;       // sticky flags
   logic              aw_ok;        // write address held
   logic [7:0]        aw_addr;      // held write address
   logic              w_ok;         // write data held
   logic [31:0]       w_data;       // held write data
   logic [3:0]        w_strb;       // held strobes
   logic              wr_go;        // write performed this cycle
   logic              blk_ev;       // one block finished on card bus
   logic              blk_crc_bad;  // that block had a crc error
   logic              last_blk;     // finished block is the final one
   logic              as_multi;     // auto stop applies to this transfer
   logic              start;        // software start request
   logic              data_rst;     // software data path reset
   logic              stop_any;     // any stop answer arrived
   logic [ST_W-1:0]   st_set;       // hardware flag sets
   logic [ST_W-1:0]   st_clr;       // software flag clears
   logic [31:0]       next_ctl;     // merged write into transfer_type_reg
   logic [31:0]       next_attr;    // merged write into block_attributes
   logic [31:0]       next_dma;     // merged write into dma address

   // card strobes cross into aclk here
   sdx_link_sampler u_link (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .card_clk         (card_clk),
      .card_blk_done    (card_blk_done),
      .card_blk_crc_bad (card_blk_crc_bad),
      .blk_ev           (blk_ev),
      .blk_crc_bad      (blk_crc_bad)
   );

   // ---------------- axi write path ----------------
   assign s_axi_awready = ~aw_ok;
   assign s_axi_wready  = ~w_ok;
   assign wr_go         = aw_ok & w_ok & ~s_axi_bvalid;
   assign next_ctl      = sdx_merge({26'h0, xfer_ctl}, w_data, w_strb);
   assign next_attr     = sdx_merge({blk_cnt, 3'h0, blk_size}, w_data, w_strb);
   assign next_dma      = sdx_merge(dma_addr, w_data, w_strb);

   // address and data taken in either order, held until performed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok   <= 1'b0;
         aw_addr <= 8'h00;
         w_ok    <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_ok) begin
            aw_ok   <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_ok <= 1'b0;
         end
         if (s_axi_wvalid && !w_ok) begin
            w_ok   <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_ok <= 1'b0;
         end
      end
   end

   // write response one cycle after the write is performed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= sdx_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- axi read path ----------------
   assign s_axi_arready = ~s_axi_rvalid;

   // data registered on the address handshake, one cycle latency
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= sdx_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            ADDR_XFER: s_axi_rdata <= {26'h0, xfer_ctl};
            ADDR_ATTR: s_axi_rdata <= {blk_cnt, 3'h0, blk_size};
            ADDR_DMA:  s_axi_rdata <= dma_addr;
            ADDR_STAT: s_axi_rdata <= {24'h0, status[ST_W-1:1], state != st_idle};
            default:   s_axi_rdata <= 32'h0000_0000;  // unmapped reads zero
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- control decode ----------------
   // start and data reset are self-clearing strobes, never stored
   assign start    = wr_go && aw_addr == ADDR_XFER && next_ctl[XT_START] && state == st_idle;
   assign data_rst = wr_go && aw_addr == ADDR_XFER && next_ctl[XT_DATA_RST];
   // without count enable the controller cannot see the end of a multi-block run
   assign last_blk = ~xfer_ctl[XT_MULTI] | (xfer_ctl[XT_BLOCK_COUNT_ENABLE] & (blk_cnt == CNT_ONE));
   assign as_multi = xfer_ctl[XT_AUTOSTOP] & xfer_ctl[XT_MULTI];
   assign stop_any = stop_resp.ok | stop_resp.timeout | stop_resp.crc_err | stop_resp.conflict;

   // transfer_type_reg: settings only change while idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xfer_ctl <= XT_RESET;
      end else if (wr_go && aw_addr == ADDR_XFER && state == st_idle) begin
         xfer_ctl <= {1'b0, next_ctl[XT_DMA:XT_BLOCK_COUNT_ENABLE], 1'b0};
      end
   end

   // ---------------- main sequencer ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= st_idle;
      end else if (data_rst) begin
         state <= st_idle;
      end else begin
         unique case (state)
            st_idle: begin
               if (start) begin
                  state <= st_data;
               end
            end
            st_data: begin
               if (dma_run && dma_bus_err) begin
                  state <= st_idle;
               end else if (blk_ev && last_blk && as_multi) begin
                  state <= st_stop;
               end else if (blk_ev && (blk_crc_bad || last_blk)) begin
                  state <= st_idle;
               end
            end
            st_stop: begin
               if (stop_any) begin
                  state <= st_idle;
               end
            end
         endcase
      end
   end

   // card bus data lines idle while the stop (addressed) command runs
   assign data_en  = state == st_data;
   assign stop_req = state == st_stop;
   assign dma_run  = state == st_data && xfer_ctl[XT_DMA];

   // block size and remaining count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blk_size <= SIZE_RESET;
         blk_cnt  <= CNT_RESET;
      end else if (wr_go && aw_addr == ADDR_ATTR) begin
         blk_size <= next_attr[SIZE_LSB +: SIZE_W];
         blk_cnt  <= next_attr[CNT_LSB +: CNT_W];
      end else if (state == st_data && blk_ev && !blk_crc_bad && xfer_ctl[XT_BLOCK_COUNT_ENABLE]) begin
         blk_cnt <= blk_cnt - CNT_ONE;
      end
   end

   // dma address advances per finished burst; a failing burst never advances it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_addr <= DMA_RESET;
      end else if (wr_go && aw_addr == ADDR_DMA) begin
         dma_addr <= next_dma;
      end else if (dma_run && dma_burst_done && !dma_bus_err) begin
         dma_addr <= dma_addr + {19'h0, blk_size};
      end
   end

   // ---------------- status flags ----------------
   always_comb begin
      st_set           = ST_RESET;
      st_set[ST_DONE]  = (state == st_data && blk_ev && last_blk && !blk_crc_bad && !as_multi)
                       || (state == st_stop && stop_resp.ok);
      st_set[ST_CRC]   = state == st_data && blk_ev && blk_crc_bad;
      st_set[ST_DMA]   = dma_run && dma_bus_err;
      st_set[ST_AS_TO] = state == st_stop && stop_resp.timeout;
      st_set[ST_AS_CE] = state == st_stop && stop_resp.crc_err;
      st_set[ST_AS_NS] = state == st_stop && stop_resp.conflict;
      st_set[ST_AS_GO] = state == st_data && blk_ev && last_blk && as_multi;
      st_clr           = (wr_go && aw_addr == ADDR_STAT) ? (w_data[ST_W-1:0] & {ST_W{w_strb[0]}})
                                                          : ST_RESET;
   end

   // write one clears; a set in the same cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= ST_RESET;
      end else begin
         status <= (status & ~st_clr) | st_set;
      end
   end

   // ---------------- assertions ----------------
   logic attr_wr;  // software writes block_attributes
   assign attr_wr = wr_go && aw_addr == ADDR_ATTR;

   no_midcrc_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == st_data && blk_ev && blk_crc_bad && !last_blk && !dma_bus_err && !data_rst
      |=> state == st_idle && !stop_req ##1 !stop_req)
      else $error("stop issued after mid-transfer crc error");
   last_crc_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == st_data && blk_ev && blk_crc_bad && last_blk && as_multi && !dma_run && !data_rst
      |=> stop_req && status[ST_CRC] && status[ST_AS_GO])
      else $error("no stop after crc error in final block");
   dma_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dma_run && dma_bus_err |=> !dma_run && status[ST_DMA] && state == st_idle)
      else $error("dma error did not abort");
   dma_addr_next_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dma_run && dma_burst_done && !dma_bus_err && !(wr_go && aw_addr == ADDR_DMA)
      |=> dma_addr == $past(dma_addr) + {19'h0, $past(blk_size)})
      else $error("dma address not at next burst");
   dma_addr_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dma_run && dma_bus_err && !(wr_go && aw_addr == ADDR_DMA) |=> $stable(dma_addr))
      else $error("dma address moved on failing burst");
   cnt_frozen_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !xfer_ctl[XT_BLOCK_COUNT_ENABLE] && !attr_wr |=> $stable(blk_cnt))
      else $error("block count changed without count enable");
   cnt_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == st_data && xfer_ctl[XT_BLOCK_COUNT_ENABLE] && blk_ev && !blk_crc_bad && !attr_wr
      |=> blk_cnt == $past(blk_cnt) - CNT_ONE)
      else $error("block count not decremented");
   auto_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == st_data && blk_ev && !blk_crc_bad && last_blk && as_multi && !dma_run && !data_rst
      |=> stop_req && status[ST_AS_GO] && !data_en)
      else $error("auto stop not issued after final block");
   stop_no_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
      stop_req |-> !data_en && !dma_run)
      else $error("data lines active during stop command");
endmodule : sdx_xfer_ctrl

// file: sim/sdx_card_model.sv
`timescale 1ns/1ps
// card stand-in: block strobes on a gated card clock, answers the stop command
module sdx_card_model (
   // clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // stop answer: kind 0 ok, 1 timeout, 2 crc, 3 conflict; wait in aclk cycles
   input  wire logic [1:0]                 stop_kind,
   input  wire logic [3:0]                 stop_wait,
   input  wire logic                       stop_req,
   output sdx_pkg::sdx_stop_resp_type      stop_resp,
   // card data path
   output logic                            card_clk,
   output logic                            card_blk_done,
   output logic                            card_blk_crc_bad
);
   import sdx_pkg::*;

   logic [4:0] wait_cnt;  // cycles since the stop request rose

   // clock stands still low between blocks
   initial begin
      card_clk         = 1'b0;
      card_blk_done    = 1'b0;
      card_blk_crc_bad = 1'b0;
   end

   // one block end: strobe held across one full card clock period
   task automatic send_block(input logic bad);
      // keep card edges off the aclk edges so the synchroniser never races them
      #5;
      card_blk_done    = 1'b1;
      card_blk_crc_bad = bad;
      #80 card_clk = 1'b1;
      #80 card_clk = 1'b0;
      card_blk_done    = 1'b0;
      // stale flag flipped so nothing can lean on it outside the strobe
      card_blk_crc_bad = ~bad;
   endtask : send_block

   // stop is an addressed command: one response pulse, nothing on the data lines
   always_ff @(posedge aclk) begin
      if (!aresetn || !stop_req) begin
         wait_cnt  <= 5'h00;
         stop_resp <= '0;
      end else begin
         wait_cnt  <= (wait_cnt == 5'h1f) ? wait_cnt : wait_cnt + 5'h01;
         stop_resp <= (wait_cnt == {1'b0, stop_wait}) ? sdx_stop_resp_type'(4'h8 >> stop_kind) : '0;
      end
   end
endmodule : sdx_card_model

// file: sim/sdx_xfer_ctrl_tb.sv
`timescale 1ns/1ps
// register bus master, card stand-in and dma strobes around the transfer controller
module sdx_xfer_ctrl_tb;
   import sdx_pkg::*;
   localparam logic [31:0] GO = 32'h1 << XT_START;
   localparam logic [31:0] BC = 32'h1 << XT_BLOCK_COUNT_ENABLE;
   localparam logic [31:0] AS = 32'h1 << XT_AUTOSTOP;
   localparam logic [31:0] MB = 32'h1 << XT_MULTI;
   localparam logic [31:0] DM = 32'h1 << XT_DMA;
   localparam logic [31:0] DR = 32'h1 << XT_DATA_RST;
   // inputs start at known levels
   logic              aclk, aresetn = 1'b0, card_clk, card_blk_done, card_blk_crc_bad, data_en, dma_run;
   logic              dma_bus_err = 1'b0, dma_burst_done = 1'b0, stop_req;
   logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic              s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, dma_addr, rd;
   logic [3:0]        s_axi_wstrb = 4'hf, stop_wait = 4'h0;
   logic [1:0]        s_axi_bresp, s_axi_rresp, resp, stop_kind = 2'h0;
   sdx_stop_resp_type stop_resp;
   int                errors = 0, n_compared = 0;

   sdx_xfer_ctrl i_sdx_xfer_ctrl (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .card_clk, .card_blk_done, .card_blk_crc_bad, .data_en, .dma_run, .dma_bus_err,
      .dma_burst_done, .dma_addr, .stop_req, .stop_resp
   );
   sdx_card_model i_sdx_card_model (
      .aclk, .aresetn, .stop_kind, .stop_wait, .stop_req, .stop_resp, .card_clk, .card_blk_done,
      .card_blk_crc_bad
   );

   // 50 mhz core clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // watchdog well past the expected run
   initial begin
      #300000;
      errors++;
      results();
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      // no timeout here: the wait ends on s_axi_bvalid, else only the watchdog ends it
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd   = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd_reg

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      rd_reg(a);
      chk(what, rd, exp);
   endtask : rchk

   // one block from the card, then time for the synchroniser
   task automatic blk(input logic bad);
      i_sdx_card_model.send_block(bad);
      repeat (6) @(posedge aclk);
   endtask : blk

   task automatic pulse(input logic err);
      @(posedge aclk);
      dma_burst_done <= 1'b1;
      dma_bus_err    <= err;
      @(posedge aclk);
      dma_burst_done <= 1'b0;
      dma_bus_err    <= 1'b0;
   endtask : pulse

   task automatic wait_idle;
      int n;
      for (n = 0; n < 40; n++) begin
         rd_reg(ADDR_STAT);
         if (rd[ST_BUSY] === 1'b0) break;
      end
   endtask : wait_idle

   task automatic start(input logic [31:0] cfg, input logic [15:0] cnt, input logic [12:0] size);
      wr(ADDR_ATTR, {cnt, 3'h0, size});
      wr(ADDR_XFER, cfg | GO);
   endtask : start

   task automatic t_reset;
      rchk("xfer", ADDR_XFER, 32'h0);
      rchk("attr", ADDR_ATTR, 32'h0);
      rchk("dma", ADDR_DMA, DMA_RESET);
      rchk("stat", ADDR_STAT, 32'h0);
      rd_reg(8'h10);
      chk("rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(8'h10, 32'hffff_ffff);
      chk("bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      $display("test reset done");
   endtask : t_reset

   // counted multi-block with auto stop, answered slowly
   task automatic t_good;
      int i;
      stop_kind <= 2'h0;
      stop_wait <= 4'hf;
      wr(ADDR_DMA, 32'h0000_1000);
      start(BC | AS | MB | DM, 16'h0003, 13'h0200);
      for (i = 0; i < 3; i++) begin
         pulse(1'b0);
         blk(1'b0);
         if (i < 2) rchk("count", ADDR_ATTR, {16'h0002 - 16'(i), 16'h0200});
      end
      chk("stop_req", {31'h0, stop_req}, 32'h1);
      wait_idle();
      rchk("stat", ADDR_STAT, 32'h82);
      rchk("dma", ADDR_DMA, 32'h0000_1600);
      wr(ADDR_STAT, 32'hfe);
      $display("test good done");
   endtask : t_good

   // crc in a middle block: no stop; software drops the rest and restarts
   task automatic t_mid_crc;
      start(BC | AS | MB, 16'h0003, 13'h0040);
      blk(1'b0);
      blk(1'b1);
      repeat (20) @(posedge aclk);
      chk("stop_req", {31'h0, stop_req}, 32'h0);
      chk("data_en", {31'h0, data_en}, 32'h0);
      rchk("stat", ADDR_STAT, 32'h04);
      wr(ADDR_STAT, 32'hfe);
      start(BC | AS | MB, 16'h0002, 13'h0040);
      blk(1'b0);
      blk(1'b0);
      wait_idle();
      rchk("stat", ADDR_STAT, 32'h82);
      wr(ADDR_STAT, 32'hfe);
      $display("test mid crc done");
   endtask : t_mid_crc

   // every stop outcome on a final block; conflict leaves a manual stop to software
   task automatic t_stop;
      int k;
      for (k = 0; k < 4; k++) begin
         stop_kind <= 2'(k);
         stop_wait <= (k == 0) ? 4'h0 : 4'hf;
         start(BC | AS | MB, 16'h0001, 13'h0040);
         blk(k == 1);
         if (k != 0) chk("stop_req", {31'h0, stop_req}, 32'h1);
         wait_idle();
         rchk("stat", ADDR_STAT, 32'h80 | ((k == 0) ? 32'h02 : 32'h08 << k) | ((k == 1) ? 32'h04 : 32'h0));
         wr(ADDR_STAT, 32'hfe);
         rchk("stat clr", ADDR_STAT, 32'h0);
         if (k == 1) begin
            // bad final block fetched again as a single block, no stop
            start(BC, 16'h0001, 13'h0040);
            blk(1'b0);
            wait_idle();
            rchk("single", ADDR_STAT, 32'h02);
            wr(ADDR_STAT, 32'hfe);
         end
      end
      $display("test stop done");
   endtask : t_stop

   // without count enable the attributes stay put
   task automatic t_nobcen;
      start(MB, 16'h0005, 13'h0040);
      blk(1'b0);
      blk(1'b0);
      rchk("count", ADDR_ATTR, 32'h0005_0040);
      chk("data_en", {31'h0, data_en}, 32'h1);
      wr(ADDR_XFER, DR);
      repeat (2) @(posedge aclk);
      chk("data_en rst", {31'h0, data_en}, 32'h0);
      $display("test no count done");
   endtask : t_nobcen

   task automatic t_dma;
      wr(ADDR_DMA, 32'h0000_2000);
      start(BC | MB | DM, 16'h0004, 13'h0200);
      pulse(1'b0);
      rchk("dma", ADDR_DMA, 32'h0000_2200);
      chk("dma_run", {31'h0, dma_run}, 32'h1);
      pulse(1'b1);
      repeat (2) @(posedge aclk);
      chk("dma_run err", {31'h0, dma_run}, 32'h0);
      rd_reg(ADDR_STAT);
      chk("dma flag", rd & 32'h08, 32'h08);
      rchk("dma err", ADDR_DMA, 32'h0000_2200);
      wr(ADDR_XFER, DR);
      wr(ADDR_STAT, 32'hfe);
      pulse(1'b0);
      rchk("dma idle", ADDR_DMA, 32'h0000_2200);
      $display("test dma done");
   endtask : t_dma

   // switch sequences: status and ext_csd reads are single counted blocks, no reset used
   task automatic t_switch;
      int j;
      for (j = 0; j < 4; j++) begin
         // query, set and restore move 64 status bytes; ext_csd is 512 bytes
         start(BC, 16'h0001, (j == 3) ? 13'h0200 : 13'h0040);
         blk(1'b0);
         wait_idle();
         rchk("switch stat", ADDR_STAT, 32'h02);
         rchk("switch attr", ADDR_ATTR, (j == 3) ? 32'h0000_0200 : 32'h0000_0040);
         wr(ADDR_STAT, 32'hfe);
      end
      $display("test switch done");
   endtask : t_switch

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_reset();
      t_good();
      t_mid_crc();
      t_stop();
      t_nobcen();
      t_dma();
      t_switch();
      results();
   end
endmodule : sdx_xfer_ctrl_tb
